/* File: src/ssc_consts.svh */
// Purpose: Offsets, field positions and reset values of the select channel.
// Assumes: A 32-bit classic Wishbone slave with byte addresses.
// Notes:   Included by its bare name.
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define SSC_OFF_DATA   8'h00
`define SSC_OFF_STAT   8'h04
`define SSC_OFF_FCLR   8'h08
`define SSC_OFF_MODE   8'h0c
`define SSC_OFF_START  8'h10
`define SSC_OFF_STOP   8'h14
`define SSC_OFF_ISC    8'h18

// ==========================================================================
// Field positions
`define SSC_ST_BFF     0
`define SSC_ST_BUSY    1
`define SSC_ST_OVF     2
`define SSC_ST_RXF     3
`define SSC_MD_CONT    0
`define SSC_MD_TXEN    1
`define SSC_MD_RXEN    2
`define SSC_MD_LSB     3
`define SSC_MD_LEN8    4
`define SSC_MD_DAP     5
`define SSC_MD_CKP     6
`define SSC_ISC_SIE    7
`define SSC_CH0        0

// ==========================================================================
// Frame lengths, reset values and register widths
`define SSC_LEN_SHORT  4'h7
`define SSC_LEN_LONG   4'h8
`define SSC_TX_IDLE    8'hff
`define SSC_STAT_W     4
`define SSC_MODE_W     7

`endif

/* File: src/ssc_pkg.sv */
// Purpose: Types shared by the select channel and its pin synchroniser.
// Assumes: Constants come from ssc_consts.svh.
// Notes:   Nothing here is imported; users write ssc_pkg::name.
package ssc_pkg;

  // ========================================================================
  // Synchroniser state of one pin
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } ssc_sync_s;

  // ========================================================================
  // Whole state of the channel
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        en;
    logic        cont;
    logic        tx_en;
    logic        rx_en;
    logic        lsb;
    logic        len8;
    logic        dap;
    logic        ckp;
    logic [7:0]  input_switch_control;
    logic [7:0]  tx_buf;
    logic        buf_full;
    logic [7:0]  tx_sh;
    logic        loaded;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_dat;
    logic        rx_full;
    logic        ovf;
    logic [3:0]  cnt;
    logic        ck_prev;
    logic        sdo;
    logic        pin;
    logic        irq;
  } ssc_state_s;

endpackage : ssc_pkg

/* File: src/ssc_sync.sv */
// Purpose: Three-stage synchroniser for pins from outside the clock domain.
// Assumes: Pins change far slower than clk_i.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none

module ssc_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] filt_o
);

  // ========================================================================
  // One chain per pin
  for (genvar i = 0; i < W; i++) begin : g_bit
    ssc_pkg::ssc_sync_s q;
    ssc_pkg::ssc_sync_s d;

    always_comb begin
      d      = q;
      d.s1   = pin_i[i];
      d.s2   = q.s1;
      d.s3   = q.s2;
      if (q.s2 == q.s3) begin
        d.filt = q.s3;
      end
      if (rst_i) begin
        d = 4'hf;
      end
    end

    always_ff @(posedge clk_i) begin
      q <= d;
    end

    assign filt_o[i] = q.filt;
  end

endmodule : ssc_sync

`default_nettype wire

/* File: src/ssc_channel.sv */
// Purpose: Serial slave channel with select input behind classic Wishbone.
// Assumes: The master clock is at most one sixth of clk_i.
// Notes:   Pins are sampled through ssc_sync before any edge is found.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.svh"

module ssc_channel (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_clock_pin_i,
  input  wire logic        slave_select_pin_i,
  input  wire logic        serial_data_in_pin_i,
  output logic             serial_data_out_pin_o,
  output logic             transfer_irq_o
);

  ssc_pkg::ssc_state_s q;
  ssc_pkg::ssc_state_s d;
  logic [2:0] pin_f;
  logic       sclk_f;
  logic       ss_f;
  logic       sdi_f;
  logic       ck_w;
  logic       rise_w;
  logic       fall_w;
  logic       sel_w;
  logic       shift_w;
  logic       samp_w;
  logic       fend_w;
  logic       load_w;
  logic       acc_w;
  logic       wr_w;
  logic       rd_w;
  logic [3:0] len_w;
  logic [3:0] nxt_w;

  // ==========================================================================
  // Pin synchronisers
  // The clock ratio leaves room for the synchroniser delay.
  ssc_sync #(
    .W (3)
  ) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  ({serial_data_in_pin_i, slave_select_pin_i, serial_clock_pin_i}),
    .filt_o (pin_f)
  );

  assign sclk_f = pin_f[0];
  assign ss_f   = pin_f[1];
  assign sdi_f  = pin_f[2];

  // Maps a bit count to a bit position in the frame.
  function automatic logic [2:0] bit_pos(input logic       lsb,
                                         input logic [3:0] len,
                                         input logic [3:0] cnt);
    logic [3:0] p;
    p = lsb ? cnt : (len - cnt - 4'h1);
    return p[2:0];
  endfunction : bit_pos

  // ==========================================================================
  // Next state
  always_comb begin
    d       = q;
    d.irq   = 1'b0;
    acc_w   = wb_cyc_i & wb_stb_i & q.ack;
    wr_w    = acc_w & wb_we_i & wb_sel_i[0];
    rd_w    = acc_w & ~wb_we_i;
    ck_w    = sclk_f ^ q.ckp;
    rise_w  = ck_w & ~q.ck_prev;
    fall_w  = ~ck_w & q.ck_prev;
    d.ck_prev = ck_w;
    len_w   = q.len8 ? `SSC_LEN_LONG : `SSC_LEN_SHORT;
    sel_w   = q.en & (~q.input_switch_control[`SSC_ISC_SIE] | ~ss_f);
    shift_w = q.dap ? rise_w : fall_w;
    samp_w  = q.dap ? fall_w : rise_w;
    nxt_w   = q.cnt + 4'h1;
    fend_w  = 1'b0;
    load_w  = 1'b0;

    // Software clears come first so that a hardware set wins.
    if (rd_w && wb_adr_i == `SSC_OFF_DATA) begin
      d.rx_full = 1'b0;
    end
    if (wr_w && wb_adr_i == `SSC_OFF_FCLR && wb_dat_i[`SSC_ST_OVF]) begin
      d.ovf = 1'b0;
    end

    // Shift engine; with select high and SIE set nothing moves.
    if (!q.en) begin
      d.cnt    = 4'h0;
      d.loaded = 1'b0;
    end else if (sel_w) begin
      if (shift_w && q.cnt < len_w) begin
        // A receive-only channel has no data of its own and sends ones.
        d.sdo = q.tx_en ? q.tx_sh[bit_pos(q.lsb, len_w, q.cnt)]
                        : 1'b1;
      end
      if (samp_w) begin
        d.rx_sh[bit_pos(q.lsb, len_w, q.cnt)] = sdi_f;
        d.cnt = nxt_w;
        if (nxt_w >= len_w) begin
          fend_w = 1'b1;
        end
      end
    end

    if (fend_w) begin
      d.cnt    = 4'h0;
      d.loaded = 1'b0;
      if (q.rx_en) begin
        d.rx_dat  = d.rx_sh;
        d.rx_full = 1'b1;
        if (q.rx_full) begin
          d.ovf = 1'b1;
        end
      end
      if (!q.cont || !q.tx_en) begin
        d.irq = 1'b1;
      end
    end

    // Buffer to shift register; data must be ready before clocking starts.
    if (q.en && q.tx_en && q.buf_full && !d.loaded && d.cnt == 4'h0) begin
      load_w   = 1'b1;
      d.tx_sh  = q.tx_buf;
      d.buf_full = 1'b0;
      d.loaded = 1'b1;
      d.sdo    = q.dap ? q.tx_buf[bit_pos(q.lsb, len_w, 4'h0)] : 1'b1;
      if (q.cont) begin
        d.irq = 1'b1;
      end
    end

    // Register writes.
    if (wr_w) begin
      case (wb_adr_i)
        `SSC_OFF_DATA: begin
          d.tx_buf   = wb_dat_i[7:0];
          d.buf_full = 1'b1;
        end
        `SSC_OFF_MODE: begin
          d.cont  = wb_dat_i[`SSC_MD_CONT];
          d.tx_en = wb_dat_i[`SSC_MD_TXEN];
          d.rx_en = wb_dat_i[`SSC_MD_RXEN];
          d.lsb   = wb_dat_i[`SSC_MD_LSB];
          d.len8  = wb_dat_i[`SSC_MD_LEN8];
          d.dap   = wb_dat_i[`SSC_MD_DAP];
          d.ckp   = wb_dat_i[`SSC_MD_CKP];
        end
        `SSC_OFF_STOP: begin
          if (wb_dat_i[`SSC_CH0]) begin
            d.en = 1'b0;
          end
        end
        `SSC_OFF_ISC: begin
          d.input_switch_control = {wb_dat_i[`SSC_ISC_SIE], 5'h00, wb_dat_i[1:0]};
        end
        default: begin
        end
      endcase
    end
    if (wr_w && wb_adr_i == `SSC_OFF_START && wb_dat_i[`SSC_CH0]) begin
      d.en = 1'b1;
    end

    // Pin is high while deselected, except a phase 1 preload.
    d.pin = (sel_w || (d.dap && d.loaded)) ? d.sdo : 1'b1;

    // Bus answer one cycle after the request.
    d.ack  = wb_cyc_i & wb_stb_i & ~q.ack;
    d.rdat = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i) begin
      case (wb_adr_i)
        `SSC_OFF_DATA:  d.rdat[7:0] = q.rx_dat;
        `SSC_OFF_STAT: begin
          d.rdat[`SSC_ST_BFF]  = q.buf_full;
          d.rdat[`SSC_ST_BUSY] = q.cnt != 4'h0;
          d.rdat[`SSC_ST_OVF]  = q.ovf;
          d.rdat[`SSC_ST_RXF]  = q.rx_full;
        end
        `SSC_OFF_MODE: begin
          d.rdat[`SSC_MODE_W-1:0] = {q.ckp, q.dap, q.len8, q.lsb,
                                     q.rx_en, q.tx_en, q.cont};
        end
        `SSC_OFF_START: d.rdat[`SSC_CH0] = q.en;
        `SSC_OFF_ISC:   d.rdat[7:0] = q.input_switch_control;
        default:        d.rdat = 32'h0000_0000;
      endcase
    end

    if (rst_i) begin
      d       = '0;
      d.tx_sh = `SSC_TX_IDLE;
      d.sdo   = 1'b1;
      d.pin   = 1'b1;
      d.len8  = 1'b1;
      d.ck_prev = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  assign wb_dat_o              = q.rdat;
  assign wb_ack_o              = q.ack;
  assign serial_data_out_pin_o = q.pin;
  assign transfer_irq_o        = q.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_len_bound;
    q.cnt <= (q.len8 ? `SSC_LEN_LONG : `SSC_LEN_SHORT);
  endproperty
  a_len_bound: assert property (p_len_bound)
    else $error("bit count beyond frame length");

  property p_idle_high;
    !sel_w && !(d.dap && d.loaded) |=> serial_data_out_pin_o;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("data out not high while deselected");

  property p_hold_desel;
    q.en && !sel_w && !wr_w |=> $stable(q.cnt) && $stable(q.rx_sh);
  endproperty
  a_hold_desel: assert property (p_hold_desel)
    else $error("channel moved while deselected");

  property p_samp_rise;
    q.en && sel_w && !q.dap && rise_w && !wr_w
      |=> q.cnt == $past(nxt_w) || q.cnt == 4'h0;
  endproperty
  a_samp_rise: assert property (p_samp_rise)
    else $error("phase 0 rising edge did not sample");

  property p_dap_preload;
    load_w && q.dap && !wr_w |=> ##1 serial_data_out_pin_o == $past(q.sdo);
  endproperty
  a_dap_preload: assert property (p_dap_preload)
    else $error("phase 1 first bit not presented");

  property p_rx_irq;
    transfer_irq_o && !q.tx_en |-> $past(fend_w);
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive only irq without frame end");

  property p_cont_irq;
    load_w && q.cont |=> transfer_irq_o;
  endproperty
  a_cont_irq: assert property (p_cont_irq)
    else $error("buffer empty irq missing");

  property p_ovf_set;
    fend_w && q.rx_en && q.rx_full |=> q.ovf && q.rx_full;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow not flagged");

  property p_overwrite;
    wr_w && wb_adr_i == `SSC_OFF_DATA |=> q.buf_full
      && q.tx_buf == $past(wb_dat_i[7:0]);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("data write did not reach buffer");

  property p_start;
    wr_w && wb_adr_i == `SSC_OFF_START && wb_dat_i[`SSC_CH0] |=> q.en;
  endproperty
  a_start: assert property (p_start)
    else $error("start write did not enable channel");

  property p_sie_off;
    !q.input_switch_control[`SSC_ISC_SIE] |-> sel_w == q.en;
  endproperty
  a_sie_off: assert property (p_sie_off)
    else $error("select pin not ignored");

  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held two cycles");

  c_frame: cover property (fend_w && q.rx_en);
  c_ovf:   cover property (fend_w && q.rx_full);
  c_cont:  cover property (load_w && q.cont);
  c_dap:   cover property (load_w && q.dap);

endmodule : ssc_channel

`default_nettype wire

/* File: tb/ssc_master_model.sv */
// Purpose: Behavioural serial master driving clock, select and data in.
// Assumes: Half period of 400 ns, eight clk_i periods per serial bit.
// Notes:   The serial clock stands still between frames.
`timescale 1ns/100ps
`default_nettype none

module ssc_master_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      sel_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o  = 1'b1;
    sel_n_o = 1'b1;
    mosi_o  = 1'b1;
  end

  // ==========================================================================
  // One frame; the bits seen on the data out pin come back in r.
  task automatic xfer(input logic [7:0] t, input int len, input logic dap,
                      input logic ckp, input logic lsb, input logic s,
                      output logic [7:0] r);
    int b;
    r = 8'h00;
    @(posedge clk_i);
    sclk_o <= !ckp;
    repeat (4) @(posedge clk_i);
    sel_n_o <= !s;
    mosi_o  <= t[lsb ? 0 : len - 1];
    repeat (8) @(posedge clk_i);
    for (int k = 0; k < len; k++) begin
      b = lsb ? k : len - 1 - k;
      if (!dap) begin
        if (k > 0) r[lsb ? k - 1 : len - k] = sdo_i;
        mosi_o <= t[b];
        sclk_o <= ckp;
        repeat (4) @(posedge clk_i);
        sclk_o <= !ckp;
        repeat (4) @(posedge clk_i);
      end else begin
        sclk_o <= ckp;
        repeat (4) @(posedge clk_i);
        r[b]   = sdo_i;
        sclk_o <= !ckp;
        if (k < len - 1) mosi_o <= t[lsb ? k + 1 : len - 2 - k];
        repeat (4) @(posedge clk_i);
      end
    end
    if (!dap) r[lsb ? len - 1 : 0] = sdo_i;
    repeat (4) @(posedge clk_i);
    sel_n_o <= 1'b1;
    mosi_o  <= !mosi_o;
    repeat (8) @(posedge clk_i);
  endtask : xfer

endmodule : ssc_master_model

`default_nettype wire

/* File: tb/ssc_channel_test.sv */
// Purpose: Self-checking bench of the select channel over Wishbone.
// Assumes: The master model keeps eight clk_i periods per serial bit.
// Notes:   Register offsets come from ssc_consts.svh.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.svh"

module ssc_channel_test;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        sclk;
  logic        ss_n;
  logic        mosi;
  logic        sdo;
  logic        irq;
  logic [31:0] q;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic [7:0]  msk;
  logic [6:0]  md;
  int          err_total;
  int          checks;
  int          irqs = 0;
  int          base;

  ssc_channel i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .serial_clock_pin_i(sclk),
    .slave_select_pin_i(ss_n), .serial_data_in_pin_i(mosi),
    .serial_data_out_pin_o(sdo), .transfer_irq_o(irq));

  ssc_master_model i_master (
    .clk_i(clk_i), .sdo_i(sdo), .sclk_o(sclk), .sel_n_o(ss_n),
    .mosi_o(mosi));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (irq === 1'b1) irqs <= irqs + 1;

  // ==========================================================================
  // Bus cycles and comparisons
  task automatic close_out;
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      $display("ERROR %0t no bus answer", $time);
      close_out();
    end
    q = rdat;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rdc

  task automatic mode(input logic [6:0] m);
    md = m;
    wb(`SSC_OFF_MODE, 1'b1, {25'h0, m});
  endtask : mode

  task automatic go(input logic [7:0] t, input logic s);
    i_master.xfer(t, md[4] ? 8 : 7, md[5], md[6], md[3], s, rx);
  endtask : go

  // ==========================================================================
  // Scenarios
  initial begin
    rst_i     = 1'b1;
    cyc       = 1'b0;
    stb       = 1'b0;
    we        = 1'b0;
    adr       = 8'h00;
    sel       = 4'hf;
    wdat      = 32'h0;
    err_total = 0;
    checks    = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`SSC_OFF_MODE, 32'h10);
    rdc(`SSC_OFF_STAT, 32'h0);
    rdc(8'hfc, 32'h0);
    sel <= 4'he;
    wb(`SSC_OFF_MODE, 1'b1, 32'h7f);
    sel <= 4'hf;
    rdc(`SSC_OFF_MODE, 32'h10);
    chk({31'h0, sdo}, 32'h1);
    wb(`SSC_OFF_START, 1'b1, 32'h1);
    rdc(`SSC_OFF_START, 32'h1);
    wb(`SSC_OFF_ISC, 1'b1, 32'h80);
    rdc(`SSC_OFF_ISC, 32'h80);
    // Every mix of data phase, clock polarity, bit order and length.
    for (int i = 0; i < 16; i++) begin
      mode({i[1], i[0], i[3], i[2], 3'b110});
      msk = md[4] ? 8'hff : 8'h7f;
      tx  = 8'h5a ^ (8'(i) * 8'h13);
      wb(`SSC_OFF_DATA, 1'b1, {24'h0, tx});
      base = irqs;
      go(tx ^ 8'hc3, 1'b1);
      chk({24'h0, rx}, {24'h0, tx & msk});
      rdc(`SSC_OFF_STAT, 32'h8);
      wb(`SSC_OFF_DATA, 1'b0, 32'h0);
      chk(q & 32'(msk), 32'((tx ^ 8'hc3) & msk));
      chk(32'(irqs - base), 32'h1);
    end
    // Deselected frames are ignored unless the select input is gated off.
    mode(7'h16);
    wb(`SSC_OFF_DATA, 1'b1, 32'h0);
    base = irqs;
    go(8'h81, 1'b0);
    chk({24'h0, rx}, 32'hff);
    rdc(`SSC_OFF_STAT, 32'h0);
    chk(32'(irqs - base), 32'h0);
    wb(`SSC_OFF_ISC, 1'b1, 32'h0);
    go(8'h81, 1'b0);
    chk({24'h0, rx}, 32'h0);
    rdc(`SSC_OFF_DATA, 32'h81);
    wb(`SSC_OFF_ISC, 1'b1, 32'h80);
    // A preloaded first bit shows while deselected.
    mode(7'h36);
    wb(`SSC_OFF_DATA, 1'b1, 32'h55);
    repeat (8) @(posedge clk_i);
    chk({31'h0, sdo}, 32'h0);
    go(8'h00, 1'b1);
    chk({24'h0, rx}, 32'h55);
    wb(`SSC_OFF_DATA, 1'b0, 32'h0);
    // Receive only: two unread frames overrun.
    mode(7'h15);
    base = irqs;
    go(8'h3c, 1'b1);
    chk({24'h0, rx}, 32'hff);
    go(8'hc3, 1'b1);
    rdc(`SSC_OFF_STAT, 32'hc);
    chk(32'(irqs - base), 32'h2);
    rdc(`SSC_OFF_DATA, 32'hc3);
    rdc(`SSC_OFF_STAT, 32'h4);
    wb(`SSC_OFF_FCLR, 1'b1, q);
    rdc(`SSC_OFF_STAT, 32'h0);
    // Continuous send: buffer-empty pulses and overwrite of pending data.
    mode(7'h17);
    base = irqs;
    wb(`SSC_OFF_DATA, 1'b1, 32'ha1);
    wb(`SSC_OFF_DATA, 1'b1, 32'h5e);
    wb(`SSC_OFF_DATA, 1'b1, 32'h3b);
    chk(32'(irqs - base), 32'h1);
    rdc(`SSC_OFF_STAT, 32'h1);
    go(8'h00, 1'b1);
    chk({24'h0, rx}, 32'ha1);
    go(8'h00, 1'b1);
    chk({24'h0, rx}, 32'h3b);
    chk(32'(irqs - base), 32'h2);
    wb(`SSC_OFF_DATA, 1'b0, 32'h0);
    wb(`SSC_OFF_STAT, 1'b0, 32'h0);
    wb(`SSC_OFF_FCLR, 1'b1, q);
    // A stopped channel ignores the master.
    wb(`SSC_OFF_STOP, 1'b1, 32'h1);
    rdc(`SSC_OFF_START, 32'h0);
    go(8'h99, 1'b1);
    rdc(`SSC_OFF_STAT, 32'h0);
    close_out();
  end

endmodule : ssc_channel_test

`default_nettype wire
